// ---- core/t1_rx_defines.svh ----
`ifndef T1_RX_DEFINES_SVH
`define T1_RX_DEFINES_SVH

// register byte addresses
`define REG_CTRL        4'h0
`define REG_STATUS      4'h4
`define REG_ATTEN       4'h8
`define REG_CVCNT       4'hc

// reset value and counter saturation limit
`define CTRL_RESET      12'h000
`define CV_MAX          16'hffff

// control register byte lanes
`define CTRL_LANE0_HI   7
`define CTRL_LANE1_LO   8
`define CTRL_LANE1_HI   11

// clock output select codes
`define CLKSEL_RECOVERED 2'h0
`define CLKSEL_HIGH      2'h1
`define CLKSEL_OSC       2'h2
`define CLKSEL_OSC_X4    2'h3

// attenuation valid pattern and field
`define ATT_VALID       2'h1
`define ATT_INVALID     2'h0

// line timing: bit period derived from clock and line rate
`define CLK_MHZ         200
`define LINE_KHZ        1544
`define BIT_CYCLES      ((`CLK_MHZ * 1000) / `LINE_KHZ)
`define PHASE_LAST      8'(`BIT_CYCLES - 1)
`define PHASE_Q1        8'(`BIT_CYCLES / 4)
`define PHASE_HALF      8'(`BIT_CYCLES / 2)
`define PHASE_Q3        8'((`BIT_CYCLES * 3) / 4)
`define PHASE_RESYNC    8'h01

// zero substitution window: 000VB0VB
`define SUBST_LEN       8
`define SUBST_SHAPE     8'h1b

// alarm thresholds in bits
`define LOS_ZERO_BITS   8'haf
`define AIS_BLOCK_LAST  11'h7ff
`define AIS_MAX_ZEROS   11'h002

`endif

// ---- core/t1_rx_pkg.sv ----
package t1_rx_pkg;

    // which line input feeds the recovery
    typedef enum logic [1:0] {
        MODE_TERNARY,
        MODE_DUAL,
        MODE_OPTICAL
    } line_mode_t;

    // one bipolar symbol as two rails
    typedef struct packed {
        logic pos;
        logic neg;
    } rail_pair_t;

    // control register layout, bit 0 last
    typedef struct packed {
        logic       cmi_select;
        logic       b8zs_enable;
        logic       system_clock_rate_select;
        logic       oscillator_switch_disable;
        logic [1:0] clock_output_select;
        logic [1:0] slice_level;
        logic       line_monitor_enable;
        logic       equalizer_long_haul_enable;
        logic       receive_code_select;
        logic       digital_receive_select;
    } ctrl_t;

    // every input arriving from outside the clock domain
    typedef struct packed {
        logic [4:0] atten;
        logic       eq_locked;
        logic [3:0] osc;
        logic       opt_clk;
        logic       opt_data;
        rail_pair_t dual;
        rail_pair_t tern;
    } pins_t;

endpackage

// ---- core/bipolar_decoder.sv ----
`timescale 1ns/1ps
`include "t1_rx_defines.svh"
module bipolar_decoder
    import t1_rx_pkg::*;
(
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    // recovered symbols
    input  wire logic       bit_valid,
    input  wire rail_pair_t rail,
    input  wire logic       b8zs_enable,
    // decoded stream
    output logic            data_out,
    output logic            data_valid,
    output logic            code_violation
);

    logic [`SUBST_LEN-1:0] pulse_h;   // pulse history, oldest at top
    logic [`SUBST_LEN-1:0] pol_h;     // polarity history, 1 is positive
    logic [`SUBST_LEN-1:0] both_h;    // both rails high at once
    logic                  last_pol;  // polarity of last pulse sent out
    logic                  primed;    // a pulse has been sent out

    // incoming symbol
    wire new_pulse = rail.pos ^ rail.neg;
    wire new_both  = rail.pos & rail.neg;

    // window as it stands once the new symbol is in
    wire [`SUBST_LEN-1:0] win_pulse = {pulse_h[`SUBST_LEN-2:0], new_pulse};
    wire [`SUBST_LEN-1:0] win_pol   = {pol_h[`SUBST_LEN-2:0], rail.pos};

    // polarity just before the window, counting the leaving symbol
    wire eff_pol = pulse_h[`SUBST_LEN-1] ? pol_h[`SUBST_LEN-1] : last_pol;

    // 000VB0VB with V in line with the preceding pulse
    wire subst_match = b8zs_enable
                     & (win_pulse == `SUBST_SHAPE)
                     & (win_pol[4] == eff_pol)
                     & (win_pol[3] != win_pol[4])
                     & (win_pol[1] == win_pol[3])
                     & (win_pol[0] != win_pol[1]);

    // violation not explained by a substitution
    wire out_viol = both_h[`SUBST_LEN-1]
                  | (pulse_h[`SUBST_LEN-1] & primed
                     & (pol_h[`SUBST_LEN-1] == last_pol));

    // shift one symbol per recovered bit; substitutions become zeros
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            pulse_h        <= '0;
            pol_h          <= '0;
            both_h         <= '0;
            last_pol       <= 1'b0;
            primed         <= 1'b0;
            data_out       <= 1'b0;
            data_valid     <= 1'b0;
            code_violation <= 1'b0;
        end else if (bit_valid) begin
            pulse_h        <= subst_match ? '0 : win_pulse;
            pol_h          <= win_pol;
            both_h         <= {both_h[`SUBST_LEN-2:0], new_both};
            data_out       <= pulse_h[`SUBST_LEN-1] | both_h[`SUBST_LEN-1];
            data_valid     <= 1'b1;
            code_violation <= out_viol;
            if (pulse_h[`SUBST_LEN-1]) begin
                last_pol <= pol_h[`SUBST_LEN-1];
                primed   <= 1'b1;
            end
        end else begin
            data_valid     <= 1'b0;
            code_violation <= 1'b0;
        end
    end

endmodule

// ---- core/t1_receive_line_decoder.sv ----
// Added by the designer: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ps
`include "t1_rx_defines.svh"
module t1_receive_line_decoder
    import t1_rx_pkg::*;
(
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    // avalon-mm slave
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [3:0]  avs_byteenable,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // line inputs
    input  wire logic        ternary_line_in_a,
    input  wire logic        ternary_line_in_b,
    input  wire logic        positive_rail_in,
    input  wire logic        negative_rail_in,
    input  wire logic        optical_data_in,
    input  wire logic        optical_receive_clock_in,
    // analog equalizer status
    input  wire logic        eq_locked,
    input  wire logic [4:0]  cable_attenuation,
    // de-jittered oscillator clocks
    input  wire logic        osc_clk_1544,
    input  wire logic        osc_clk_2048,
    input  wire logic        osc_clk_6176,
    input  wire logic        osc_clk_8192,
    // analog front end controls
    output logic             equalizer_long_haul_enable,
    output logic             line_monitor_enable,
    output logic      [1:0]  slice_level,
    output logic             oscillator_switch_disable,
    // recovered stream and clocks
    output logic             rx_data,
    output logic             rx_data_valid,
    output logic             recovered_clk,
    output logic             route_clock_out,
    // alarms
    output logic             ais_alarm,
    output logic             los_alarm
);

    pins_t       pin_raw;        // raw pins gathered
    pins_t       sync1;          // first synchroniser stage
    pins_t       sync2;          // second stage, safe to use
    ctrl_t       ctrl;           // control register
    logic        ack;            // bus answer cycle
    logic [15:0] cv_count;       // code violation counter
    logic [7:0]  att_reg;        // attenuation status
    logic [7:0]  phase;          // position within a bit period
    logic        lvl_prev;       // last recovery level
    logic        seen_pos;       // positive pulse seen this bit
    logic        seen_neg;       // negative pulse seen this bit
    logic        cmi_first;      // first half of a cmi symbol
    logic        opt_clk_prev;   // last optical clock level
    logic [7:0]  zero_run;       // consecutive zero bits
    logic [10:0] ais_bits;       // bits in current ais block
    logic [10:0] ais_zeros;      // zeros in current ais block
    logic        dec_data;       // decoder output bit
    logic        dec_valid;      // decoder output strobe
    logic        dec_cv;         // decoder violation strobe

    // decode line mode from the two select bits
    function automatic line_mode_t decode_mode(input ctrl_t c);
        if (!c.digital_receive_select)
            return MODE_TERNARY;
        else if (c.receive_code_select)
            return MODE_DUAL;
        else
            return MODE_OPTICAL;
    endfunction

    // gather pins for synchronisation
    assign pin_raw = '{atten:     cable_attenuation,
                       eq_locked: eq_locked,
                       osc:       {osc_clk_8192, osc_clk_6176,
                                   osc_clk_2048, osc_clk_1544},
                       opt_clk:   optical_receive_clock_in,
                       opt_data:  optical_data_in,
                       dual:      '{pos: positive_rail_in,
                                    neg: negative_rail_in},
                       tern:      '{pos: ternary_line_in_a,
                                    neg: ternary_line_in_b}};

    // two-stage synchroniser for all outside inputs
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            sync1 <= '0;
            sync2 <= '0;
        end else begin
            sync1 <= pin_raw;
            sync2 <= sync1;
        end
    end

    wire        bus_req  = avs_read | avs_write;
    wire        bus_take = bus_req & ~ack;     // first cycle of a request
    wire        wr_acc   = avs_write & ack;    // write takes effect here
    wire        sel_ctrl = (avs_address == `REG_CTRL);
    wire        sel_stat = (avs_address == `REG_STATUS);
    wire        sel_att  = (avs_address == `REG_ATTEN);
    wire        sel_cv   = (avs_address == `REG_CVCNT);
    wire        cv_take  = avs_read & ~ack & sel_cv;

    // one wait state on every access
    assign avs_waitrequest = bus_req & ~ack;

    // read mux; unmapped reads give zero
    wire [31:0] rd_mux = sel_ctrl ? {20'h0, ctrl} :
                         sel_stat ? {30'h0, los_alarm, ais_alarm} :
                         sel_att  ? {24'h0, att_reg} :
                         sel_cv   ? {16'h0, cv_count} : 32'h0;

    // answer flag and captured read data
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ack          <= 1'b0;
            avs_readdata <= 32'h0;
        end else begin
            ack <= bus_take;
            if (bus_take & avs_read)
                avs_readdata <= rd_mux;
        end
    end

    // control register, byte lanes honoured; unmapped writes dropped
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ctrl <= `CTRL_RESET;
        end else if (wr_acc & sel_ctrl) begin
            if (avs_byteenable[0])
                ctrl[`CTRL_LANE0_HI:0] <= avs_writedata[`CTRL_LANE0_HI:0];
            if (avs_byteenable[1])
                ctrl[`CTRL_LANE1_HI:`CTRL_LANE1_LO] <=
                    avs_writedata[`CTRL_LANE1_HI:`CTRL_LANE1_LO];
        end
    end

    // front end controls straight from the register
    assign equalizer_long_haul_enable = ctrl.equalizer_long_haul_enable;
    assign line_monitor_enable        = ctrl.line_monitor_enable;
    assign slice_level                = ctrl.slice_level;
    assign oscillator_switch_disable  = ctrl.oscillator_switch_disable;

    wire line_mode_t mode     = decode_mode(ctrl);
    wire             opt_mode = (mode == MODE_OPTICAL);
    wire             nrz_mode = opt_mode & ~ctrl.cmi_select;
    wire             cmi_mode = opt_mode & ctrl.cmi_select;

    // dual rail skips equalizer status and feeds recovery directly
    wire rail_pair_t line_rail = (mode == MODE_DUAL) ? sync2.dual
                                                     : sync2.tern;

    // level whose edges resync the bit clock
    wire lvl      = opt_mode ? sync2.opt_data
                             : (line_rail.pos | line_rail.neg);
    // bipolar pulses start a bit; cmi falls only at bit boundaries
    wire lvl_edge = opt_mode ? (lvl_prev & ~lvl)
                             : (~lvl_prev & lvl);
    wire strobe   = (phase == `PHASE_Q3) & ~nrz_mode;
    wire sample1  = (phase == `PHASE_Q1);

    // bit-clock recovery: phase counter pulled in by line edges
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            phase    <= 8'h00;
            lvl_prev <= 1'b0;
        end else begin
            lvl_prev <= lvl;
            if (lvl_edge)
                phase <= `PHASE_RESYNC;
            else if (phase == `PHASE_LAST)
                phase <= 8'h00;
            else
                phase <= phase + 8'h01;
        end
    end

    // pulse catchers; 50% duty pulses land before the sample point
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            seen_pos  <= 1'b0;
            seen_neg  <= 1'b0;
            cmi_first <= 1'b0;
        end else begin
            seen_pos <= (seen_pos & ~strobe) | line_rail.pos;
            seen_neg <= (seen_neg & ~strobe) | line_rail.neg;
            if (sample1)
                cmi_first <= sync2.opt_data;
        end
    end

    // cmi: equal halves are a one, polarity from level; else zero
    wire        cmi_one  = (cmi_first == sync2.opt_data);
    wire rail_pair_t cmi_rail = '{pos: cmi_one & sync2.opt_data,
                                  neg: cmi_one & ~sync2.opt_data};
    wire rail_pair_t bip_rail = '{pos: seen_pos | line_rail.pos,
                                  neg: seen_neg | line_rail.neg};
    wire rail_pair_t dec_rail = cmi_mode ? cmi_rail : bip_rail;

    // bipolar decoding with zero substitution removal
    bipolar_decoder u_decoder (
        .ref_clk        (ref_clk),
        .rst_n          (rst_n),
        .bit_valid      (strobe),
        .rail           (dec_rail),
        .b8zs_enable    (ctrl.b8zs_enable),
        .data_out       (dec_data),
        .data_valid     (dec_valid),
        .code_violation (dec_cv)
    );

    // nrz: sample data at the falling receive clock edge
    wire opt_fall = opt_clk_prev & ~sync2.opt_clk;
    wire bit_v    = nrz_mode ? opt_fall : dec_valid;
    wire bit_d    = nrz_mode ? sync2.opt_data : dec_data;
    wire cv_inc   = dec_cv & ~nrz_mode;

    // single-rail output stream
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            opt_clk_prev  <= 1'b0;
            rx_data       <= 1'b0;
            rx_data_valid <= 1'b0;
        end else begin
            opt_clk_prev  <= sync2.opt_clk;
            rx_data_valid <= bit_v;
            if (bit_v)
                rx_data <= bit_d;
        end
    end

    // violation counter: saturating, cleared on read, count wins
    always_ff @(posedge ref_clk) begin
        if (!rst_n)
            cv_count <= 16'h0000;
        else if (cv_take)
            cv_count <= {15'h0000, cv_inc};
        else if (cv_inc && cv_count != `CV_MAX)
            cv_count <= cv_count + 16'h0001;
    end

    // attenuation status: valid pattern over the 5-bit value
    always_ff @(posedge ref_clk) begin
        if (!rst_n)
            att_reg <= 8'h00;
        else
            att_reg <= {sync2.eq_locked ? `ATT_VALID : `ATT_INVALID,
                        1'b0, sync2.atten};
    end

    // alarms from the recovered stream
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            zero_run  <= 8'h00;
            los_alarm <= 1'b0;
            ais_bits  <= 11'h000;
            ais_zeros <= 11'h000;
            ais_alarm <= 1'b0;
        end else if (bit_v) begin
            if (bit_d) begin
                zero_run  <= 8'h00;
                los_alarm <= 1'b0;
            end else if (zero_run != `LOS_ZERO_BITS) begin
                zero_run  <= zero_run + 8'h01;
            end else begin
                los_alarm <= 1'b1;
            end
            if (ais_bits == `AIS_BLOCK_LAST) begin
                ais_alarm <= (ais_zeros + {10'h000, ~bit_d})
                             <= `AIS_MAX_ZEROS;
                ais_bits  <= 11'h000;
                ais_zeros <= 11'h000;
            end else begin
                ais_bits  <= ais_bits + 11'h001;
                ais_zeros <= ais_zeros + {10'h000, ~bit_d};
            end
        end
    end

    // recovered clock: counter phase, or the nrz receive clock
    wire rec_clk = nrz_mode ? sync2.opt_clk : (phase < `PHASE_HALF);
    // oscillator clock chosen by rate bit
    wire osc_lo  = ctrl.system_clock_rate_select ? sync2.osc[0] : sync2.osc[1];
    wire osc_hi  = ctrl.system_clock_rate_select ? sync2.osc[2] : sync2.osc[3];

    // route clock output multiplexer
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            recovered_clk   <= 1'b0;
            route_clock_out <= 1'b0;
        end else begin
            recovered_clk <= rec_clk;
            unique case (ctrl.clock_output_select)
                `CLKSEL_RECOVERED: route_clock_out <= rec_clk;
                `CLKSEL_HIGH:      route_clock_out <= 1'b1;
                `CLKSEL_OSC:       route_clock_out <= osc_lo;
                `CLKSEL_OSC_X4:    route_clock_out <= osc_hi;
            endcase
        end
    end

    // checks, all on the system clock
    default clocking chk_cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);
    sequence bus_wait_s;
        bus_req && avs_waitrequest;
    endsequence
    sequence sel_high_s;
        (ctrl.clock_output_select == `CLKSEL_HIGH) [*2];
    endsequence
    bus_one_wait_a: assert property (bus_wait_s |=> !avs_waitrequest)
        else $error("bus answer not after one wait");
    ternary_sel_a: assert property (
        !ctrl.digital_receive_select |-> mode == MODE_TERNARY && line_rail == sync2.tern)
        else $error("ternary input not selected");
    dual_sel_a: assert property (
        ctrl.digital_receive_select && ctrl.receive_code_select |-> line_rail == sync2.dual)
        else $error("dual-rail input not selected");
    optical_sel_a: assert property (
        ctrl.digital_receive_select && !ctrl.receive_code_select |-> opt_mode)
        else $error("optical input not selected");
    short_haul_a: assert property (
        !$past(rst_n) |-> !equalizer_long_haul_enable)
        else $error("long-haul active after reset");
    att_valid_a: assert property (
        att_reg[7:6] == `ATT_VALID |-> $past(sync2.eq_locked))
        else $error("attenuation valid without lock");
    clk_high_a: assert property (sel_high_s |-> route_clock_out)
        else $error("route clock not held high");
    nrz_sample_a: assert property (
        nrz_mode && opt_fall |=> rx_data_valid && rx_data == $past(sync2.opt_data))
        else $error("nrz bit not taken on falling edge");
    nrz_no_cv_a: assert property (
        nrz_mode && !cv_take && $past(nrz_mode) |=> $stable(cv_count))
        else $error("violation counted in nrz mode");
    cv_clear_a: assert property (cv_take |=> cv_count <= 16'h0001)
        else $error("counter not cleared on read");
    cv_saturate_a: assert property (
        cv_count == `CV_MAX && !cv_take |=> cv_count == `CV_MAX)
        else $error("counter wrapped");

endmodule

// ---- test/line_tx_model.sv ----
`timescale 1ns/1ps
module line_tx_model (
    // clock
    input  wire logic ref_clk,
    // bit source
    input  wire logic send_ones,
    input  wire logic violate,
    // bipolar line
    output logic      pos,
    output logic      neg
);
    logic [7:0] phase;    // place within a bit period
    logic       last_pos; // polarity of the previous mark
    logic       p;        // polarity of the mark now sent
    initial begin
        phase = 8'h00;
        last_pos = 1'b0;
        pos = 1'b0;
        neg = 1'b0;
    end
    // one bit per 129 cycles; marks alternate unless a violation is asked
    always @(posedge ref_clk) begin
        phase <= (phase == 8'h80) ? 8'h00 : phase + 8'h01;
        if (phase == 8'h00) begin
            p = violate ? last_pos : !last_pos;
            if (send_ones) begin
                last_pos <= p;
                pos <= p;
                neg <= !p;
            end
        end else if (phase == 8'h40) begin
            // half-width pulse, then the line returns to zero
            pos <= 1'b0;
            neg <= 1'b0;
        end
    end
endmodule

// ---- test/t1_receive_line_decoder_tb.sv ----
`timescale 1ns/1ps
module t1_receive_line_decoder_tb;
    logic        ref_clk, rst_n, rd, wr, wait_req, send_ones, violate, oclk;
    logic        eq_locked, long_haul, monitor, osc_dis, rx_data, rx_valid;
    logic        rec_clk, route_clk, ais, los, pos, neg;
    logic [1:0]  slice;
    logic [3:0]  adr;
    logic [4:0]  atten;
    logic [31:0] wdata, rdata, got;
    int          error_cnt, checks, cycles;

    // system clock, and an unrelated link clock
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    initial begin
        oclk = 1'b0;
        #7;
        forever #32 oclk = ~oclk;
    end

    // one avalon access; request held to the rising edge that samples waitrequest low
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        wr <= w;
        rd <= !w;
        adr <= a;
        wdata <= d;
        do begin
            @(posedge ref_clk);
        end while (wait_req !== 1'b0);
        got = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask

    task automatic check(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic tally_and_finish;
        if (error_cnt == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // one bit with a same-polarity mark, then time to pass the decoder
    task automatic send_violation;
        violate <= 1'b1;
        repeat (129) @(posedge ref_clk);
        violate <= 1'b0;
        repeat (12 * 129) @(posedge ref_clk);
    endtask

    // hang guard
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            error_cnt++;
            tally_and_finish();
        end
    end

    line_tx_model line_tx_model_inst (
        .ref_clk   (ref_clk),
        .send_ones (send_ones),
        .violate   (violate),
        .pos       (pos),
        .neg       (neg)
    );

    t1_receive_line_decoder t1_receive_line_decoder_inst (
        .ref_clk(ref_clk), .rst_n(rst_n), .avs_address(adr), .avs_read(rd),
        .avs_write(wr), .avs_byteenable(4'hf), .avs_writedata(wdata),
        .avs_readdata(rdata), .avs_waitrequest(wait_req),
        .ternary_line_in_a(pos), .ternary_line_in_b(neg), .positive_rail_in(pos),
        .negative_rail_in(neg), .optical_data_in(pos), .optical_receive_clock_in(oclk),
        .eq_locked(eq_locked), .cable_attenuation(atten), .osc_clk_1544(oclk),
        .osc_clk_2048(1'b0), .osc_clk_6176(1'b0), .osc_clk_8192(1'b0),
        .equalizer_long_haul_enable(long_haul), .line_monitor_enable(monitor),
        .slice_level(slice), .oscillator_switch_disable(osc_dis), .rx_data(rx_data),
        .rx_data_valid(rx_valid), .recovered_clk(rec_clk), .route_clock_out(route_clk),
        .ais_alarm(ais), .los_alarm(los)
    );

    // main sequence
    initial begin
        {rst_n, rd, wr, send_ones, violate, adr, wdata} = '0;
        {eq_locked, atten} = 6'h25;
        {error_cnt, checks, cycles} = '0;
        repeat (5) @(posedge ref_clk);
        rst_n <= 1'b1;
        bus(0, 4'h0, 0);
        check(got, 32'h0);
        bus(0, 4'h8, 0);
        check(got, 32'h45);
        eq_locked <= 1'b0;
        repeat (4) @(posedge ref_clk);
        bus(0, 4'h8, 0);
        check(got, 32'h05);
        bus(0, 4'h6, 0);
        check(got, 32'h0);
        bus(1, 4'h0, 32'h17c);
        repeat (2) @(posedge ref_clk);
        check({26'h0, osc_dis, route_clk, long_haul, monitor, slice}, 32'h3f);
        bus(0, 4'h0, 0);
        check(got, 32'h17c);
        repeat (180 * 129) @(posedge ref_clk);
        bus(0, 4'h4, 0);
        check(got, 32'h2);
        bus(1, 4'h0, 32'h0);
        send_ones <= 1'b1;
        repeat (20 * 129) @(posedge ref_clk);
        check({30'h0, los, rx_data}, 32'h1);
        check({31'h0, route_clk}, {31'h0, rec_clk});
        bus(0, 4'hc, 0);
        send_violation();
        bus(0, 4'hc, 0);
        check(got, 32'h1);
        bus(0, 4'hc, 0);
        check(got, 32'h0);
        bus(1, 4'h0, 32'h3);
        bus(0, 4'hc, 0);
        send_violation();
        bus(0, 4'hc, 0);
        check(got, 32'h1);
        bus(1, 4'h0, 32'h1);
        bus(0, 4'hc, 0);
        send_violation();
        bus(0, 4'hc, 0);
        check(got, 32'h0);
        tally_and_finish();
    end
endmodule
